// *** rtl/eight_bit_arith_logic_unit.sv ***
// arithmetic and logic execution datapath with register file and memory operand path
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module eight_bit_arith_logic_unit
    import alu_pkg::*;
(
    // clock and reset
    input wire logic MCLK,
    input wire logic RESET_N,
    // operation request from the sequencer
    input wire logic OP_VALID,
    input wire op_t OP_CODE,
    input wire logic [2:0] OP_SEL,
    input wire logic [1:0] OP_PAIR,
    input wire logic OP_IMM,
    input wire logic [7:0] IMM_DATA,
    output logic BUSY,
    output logic DONE,
    // memory operand path
    output logic [15:0] MEM_ADDR,
    output logic MEM_RD,
    output logic MEM_WR,
    output logic [7:0] MEM_WDATA,
    input wire logic [7:0] MEM_RDATA,
    // register port
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA
);
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_run = 2'b01,
        st_last = 2'b11
    } state_t;

    state_t state_reg;
    logic [3:0] cnt_reg;
    op_t op_reg;
    logic [2:0] sel_reg;
    logic [1:0] pair_reg;
    logic mem_op_reg;
    logic [7:0] operand_reg;
    logic mem_rd_d_reg;
    logic [7:0] byte_reg [0:7];
    logic [15:0] sp_reg;
    logic [15:0] mem_addr_reg;
    logic mem_rd_reg;
    logic mem_wr_reg;
    logic [7:0] mem_wdata_reg;
    logic busy_reg;
    logic done_reg;
    logic [7:0] rdata_reg;
    logic accept;
    logic commit;
    logic needs_mem;
    logic [15:0] pair_now;
    logic [15:0] hl_now;
    logic [16:0] hl_sum;
    logic [15:0] pair_next;

    alu_link_if link ();

    byte_alu u_byte_alu (
        .link(link)
    );

    // =========================================================
    // decoding helpers
    function automatic logic [7:0] sel_byte(input logic [2:0] sel);
        sel_byte = byte_reg[sel];
    endfunction

    function automatic logic [15:0] pair_value(input logic [1:0] p);
        case (p)
            PAIR_BC: pair_value = {byte_reg[SEL_B], byte_reg[SEL_C]};
            PAIR_DE: pair_value = {byte_reg[SEL_D], byte_reg[SEL_E]};
            PAIR_HL: pair_value = {byte_reg[SEL_H], byte_reg[SEL_L]};
            default: pair_value = sp_reg;
        endcase
    endfunction

    function automatic logic uses_byte_operand(input op_t op);
        uses_byte_operand = (op != op_increment_pair) && (op != op_decrement_pair) &&
                            (op != op_pair_add_to_hl) && (op != op_decimal_adjust);
    endfunction

    function automatic logic [3:0] op_states(input op_t op, input logic mem, input logic imm);
        case (op)
            op_increment_byte, op_decrement_byte: op_states = mem ? CNT_LONG : CNT_STEP;
            op_increment_pair, op_decrement_pair: op_states = CNT_STEP;
            op_pair_add_to_hl, op_decimal_adjust: op_states = CNT_LONG;
            default: op_states = (mem || imm) ? CNT_OPERAND : CNT_REG;
        endcase
    endfunction

    assign accept = (state_reg == st_idle) && OP_VALID;
    assign commit = (state_reg == st_last);
    assign needs_mem = uses_byte_operand(OP_CODE) && !OP_IMM && (OP_SEL == SEL_MEM);
    assign hl_now = pair_value(PAIR_HL);
    assign pair_now = pair_value(pair_reg);
    assign hl_sum = {1'b0, hl_now} + {1'b0, pair_now};
    // pairs wrap at 16 bits by truncation
    assign pair_next = (op_reg == op_increment_pair) ? pair_now + 16'h0001
                                                     : pair_now - 16'h0001;

    always_comb begin
        link.op = op_reg;
        link.acc = byte_reg[SEL_A];
        link.operand = operand_reg;
        link.flags_in = byte_reg[SLOT_FLAGS];
    end

    // =========================================================
    // sequencing
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_reg <= st_idle;
            cnt_reg <= 4'h0;
        end else begin
            case (state_reg)
                st_idle: begin
                    if (accept) begin
                        state_reg <= st_run;
                        cnt_reg <= op_states(OP_CODE, needs_mem, OP_IMM);
                    end
                end
                st_run: begin
                    cnt_reg <= cnt_reg - 4'h1;
                    if (cnt_reg == 4'h2) begin
                        state_reg <= st_last;
                    end
                end
                st_last: begin
                    state_reg <= st_idle;
                    cnt_reg <= 4'h0;
                end
                default: begin
                    state_reg <= st_idle;
                    cnt_reg <= 4'h0;
                end
            endcase
        end
    end

    // request capture and operand selection
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            op_reg <= op_add_with_carry;
            sel_reg <= SEL_B;
            pair_reg <= PAIR_BC;
            mem_op_reg <= 1'b0;
            operand_reg <= BYTE_RESET;
            mem_rd_d_reg <= 1'b0;
        end else begin
            mem_rd_d_reg <= mem_rd_reg;
            if (accept) begin
                op_reg <= OP_CODE;
                sel_reg <= OP_SEL;
                pair_reg <= OP_PAIR;
                mem_op_reg <= needs_mem;
                operand_reg <= OP_IMM ? IMM_DATA : sel_byte(OP_SEL);
            end else if (mem_rd_d_reg) begin
                operand_reg <= MEM_RDATA;
            end
        end
    end

    // memory operand path: read at HL when accepted, write back before the end
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mem_addr_reg <= 16'h0000;
            mem_rd_reg <= 1'b0;
            mem_wr_reg <= 1'b0;
            mem_wdata_reg <= BYTE_RESET;
        end else begin
            mem_rd_reg <= accept && needs_mem;
            mem_wr_reg <= 1'b0;
            if (accept && needs_mem) begin
                mem_addr_reg <= hl_now;
            end
            if ((state_reg == st_run) && (cnt_reg == 4'h2) && mem_op_reg &&
                ((op_reg == op_increment_byte) || (op_reg == op_decrement_byte))) begin
                mem_wr_reg <= 1'b1;
                mem_wdata_reg <= link.result;
            end
        end
    end

    // register file: software writes refused while an operation runs
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < 8; i++) begin
                byte_reg[i] <= BYTE_RESET;
            end
            byte_reg[SLOT_FLAGS] <= FLAGS_RESET;
            sp_reg <= SP_RESET;
        end else if (commit) begin
            case (op_reg)
                op_compare_operand: begin
                    byte_reg[SLOT_FLAGS] <= link.flags_out;
                end
                op_increment_byte, op_decrement_byte: begin
                    if (!mem_op_reg) begin
                        byte_reg[sel_reg] <= link.result;
                    end
                    byte_reg[SLOT_FLAGS] <= {link.flags_out[7:1],
                                             byte_reg[SLOT_FLAGS][FLAG_CARRY]};
                end
                op_increment_pair, op_decrement_pair: begin
                    if (pair_reg == PAIR_SP) begin
                        sp_reg <= pair_next;
                    end else begin
                        byte_reg[{pair_reg, 1'b0}] <= pair_next[15:8];
                        byte_reg[{pair_reg, 1'b1}] <= pair_next[7:0];
                    end
                end
                op_pair_add_to_hl: begin
                    byte_reg[SEL_H] <= hl_sum[15:8];
                    byte_reg[SEL_L] <= hl_sum[7:0];
                    byte_reg[SLOT_FLAGS][FLAG_CARRY] <= hl_sum[16];
                end
                default: begin
                    byte_reg[SEL_A] <= link.result;
                    byte_reg[SLOT_FLAGS] <= link.flags_out;
                end
            endcase
        end else if (REG_WR && !busy_reg) begin
            if (REG_ADDR[3] == 1'b0) begin
                byte_reg[REG_ADDR[2:0]] <= REG_WDATA;
            end else if (REG_ADDR == OFS_SP_LOW) begin
                sp_reg[7:0] <= REG_WDATA;
            end else if (REG_ADDR == OFS_SP_HIGH) begin
                sp_reg[15:8] <= REG_WDATA;
            end
        end
    end

    // status and register read port
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            done_reg <= commit;
            if (accept) begin
                busy_reg <= 1'b1;
            end else if (commit) begin
                busy_reg <= 1'b0;
            end
            rdata_reg <= 8'h00;
            if (REG_RD) begin
                if (REG_ADDR[3] == 1'b0) begin
                    rdata_reg <= byte_reg[REG_ADDR[2:0]];
                end else if (REG_ADDR == OFS_SP_LOW) begin
                    rdata_reg <= sp_reg[7:0];
                end else if (REG_ADDR == OFS_SP_HIGH) begin
                    rdata_reg <= sp_reg[15:8];
                end else if (REG_ADDR == OFS_STATUS) begin
                    rdata_reg <= {7'h00, busy_reg};
                end
            end
        end
    end

    assign BUSY = busy_reg;
    assign DONE = done_reg;
    assign MEM_ADDR = mem_addr_reg;
    assign MEM_RD = mem_rd_reg;
    assign MEM_WR = mem_wr_reg;
    assign MEM_WDATA = mem_wdata_reg;
    assign REG_RDATA = rdata_reg;

    // =========================================================
    // checks; snapshots are taken only for the checks below
    logic [7:0] acc_start_reg;
    logic [7:0] flags_start_reg;
    logic [15:0] hl_start_reg;

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            acc_start_reg <= 8'h00;
            flags_start_reg <= 8'h00;
            hl_start_reg <= 16'h0000;
        end else if (accept) begin
            acc_start_reg <= byte_reg[SEL_A];
            flags_start_reg <= byte_reg[SLOT_FLAGS];
            hl_start_reg <= hl_now;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);

    sequence busy_four;
        BUSY[*4] ##1 (DONE && !BUSY);
    endsequence

    sequence busy_seven;
        BUSY[*7] ##1 (DONE && !BUSY);
    endsequence

    sequence busy_five;
        BUSY[*5] ##1 (DONE && !BUSY);
    endsequence

    chk_reg_logic_timing: assert property (
        accept && !OP_IMM && (OP_SEL != SEL_MEM) &&
        ((OP_CODE == op_and_operand) || (OP_CODE == op_compare_operand) ||
         (OP_CODE == op_minus)) |=> busy_four)
        else $error("register operand operation not four states");

    chk_operand_timing: assert property (
        accept && (OP_IMM || (OP_SEL == SEL_MEM)) && (OP_CODE == op_or_operand)
        |=> busy_seven)
        else $error("memory or immediate operation not seven states");

    chk_pair_step_timing: assert property (
        accept && ((OP_CODE == op_increment_pair) || (OP_CODE == op_decrement_pair))
        |=> busy_five)
        else $error("pair step not five states");

    chk_mem_read_hl: assert property (
        accept && needs_mem |=> MEM_RD && (MEM_ADDR == hl_start_reg) ##1 !MEM_RD)
        else $error("memory operand not read at HL");

    chk_mem_write_back: assert property (
        accept && needs_mem && (OP_CODE == op_increment_byte)
        |=> (!MEM_WR)[*8] ##1 !MEM_WR ##1 (MEM_WR && (MEM_WDATA == operand_reg + 8'h01)) ##1 DONE)
        else $error("memory increment write back wrong");

    chk_step_keeps_carry: assert property (
        DONE && ((op_reg == op_increment_byte) || (op_reg == op_decrement_byte))
        |-> byte_reg[SLOT_FLAGS][FLAG_CARRY] == flags_start_reg[FLAG_CARRY])
        else $error("byte step changed carry");

    chk_pair_no_flags: assert property (
        DONE && ((op_reg == op_increment_pair) || (op_reg == op_decrement_pair))
        |-> byte_reg[SLOT_FLAGS] == flags_start_reg)
        else $error("pair step changed flags");

    chk_and_clears: assert property (
        DONE && (op_reg == op_and_operand) |-> !byte_reg[SLOT_FLAGS][FLAG_CARRY])
        else $error("and left carry set");

    chk_xor_or_clear: assert property (
        DONE && ((op_reg == op_xor_operand) || (op_reg == op_or_operand))
        |-> !byte_reg[SLOT_FLAGS][FLAG_CARRY] && !byte_reg[SLOT_FLAGS][FLAG_HALF])
        else $error("xor or or left carry flags set");

    chk_cmp_flags: assert property (
        DONE && (op_reg == op_compare_operand)
        |-> (byte_reg[SEL_A] == acc_start_reg) &&
            (byte_reg[SLOT_FLAGS][FLAG_ZERO] == (acc_start_reg == operand_reg)) &&
            (byte_reg[SLOT_FLAGS][FLAG_CARRY] == (acc_start_reg < operand_reg)))
        else $error("compare flags or accumulator wrong");

    chk_pair_add_carry: assert property (
        DONE && (op_reg == op_pair_add_to_hl) && (pair_reg != PAIR_HL)
        |-> {byte_reg[SLOT_FLAGS][FLAG_CARRY], byte_reg[SEL_H], byte_reg[SEL_L]} ==
            ({1'b0, hl_start_reg} + {1'b0, pair_now}))
        else $error("pair add result or carry wrong");

endmodule // eight_bit_arith_logic_unit
`default_nettype wire

// *** rtl/alu_pkg.sv ***
// package: operation codes, selectors, register map, flag layout and timing counts
package alu_pkg;

    typedef enum logic [3:0] {
        op_add_with_carry = 4'h0,
        op_minus = 4'h1,
        op_minus_with_borrow = 4'h2,
        op_and_operand = 4'h3,
        op_xor_operand = 4'h4,
        op_or_operand = 4'h5,
        op_compare_operand = 4'h6,
        op_increment_byte = 4'h7,
        op_decrement_byte = 4'h8,
        op_increment_pair = 4'h9,
        op_decrement_pair = 4'hA,
        op_pair_add_to_hl = 4'hB,
        op_decimal_adjust = 4'hC
    } op_t;

    // byte selector codes; slot 6 of the register array holds the flags
    localparam logic [2:0] SEL_B = 3'h0;
    localparam logic [2:0] SEL_C = 3'h1;
    localparam logic [2:0] SEL_D = 3'h2;
    localparam logic [2:0] SEL_E = 3'h3;
    localparam logic [2:0] SEL_H = 3'h4;
    localparam logic [2:0] SEL_L = 3'h5;
    localparam logic [2:0] SEL_MEM = 3'h6;
    localparam logic [2:0] SEL_A = 3'h7;
    localparam logic [2:0] SLOT_FLAGS = 3'h6;

    localparam logic [1:0] PAIR_BC = 2'h0;
    localparam logic [1:0] PAIR_DE = 2'h1;
    localparam logic [1:0] PAIR_HL = 2'h2;
    localparam logic [1:0] PAIR_SP = 2'h3;

    // register bus offsets; 0..7 follow the byte selector slots
    localparam logic [3:0] OFS_SP_LOW = 4'h8;
    localparam logic [3:0] OFS_SP_HIGH = 4'h9;
    localparam logic [3:0] OFS_STATUS = 4'hA;

    localparam int FLAG_SIGN = 7;
    localparam int FLAG_ZERO = 6;
    localparam int FLAG_HALF = 4;
    localparam int FLAG_PARITY = 2;
    localparam int FLAG_CARRY = 0;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] SP_RESET = 16'h0000;

    // one processor state is one MCLK period
    localparam int STATE_CYCLES = 1;
    localparam int STATES_REG = 4;
    localparam int STATES_OPERAND = 7;
    localparam int STATES_STEP = 5;
    localparam int STATES_LONG = 10;
    localparam logic [3:0] CNT_REG = 4'(STATES_REG * STATE_CYCLES);
    localparam logic [3:0] CNT_OPERAND = 4'(STATES_OPERAND * STATE_CYCLES);
    localparam logic [3:0] CNT_STEP = 4'(STATES_STEP * STATE_CYCLES);
    localparam logic [3:0] CNT_LONG = 4'(STATES_LONG * STATE_CYCLES);

endpackage

// *** rtl/alu_link_if.sv ***
// interface: operands and results between sequencing core and byte arithmetic unit
`timescale 1ns/1ns
`default_nettype none
interface alu_link_if;
    import alu_pkg::*;
    op_t op;
    logic [7:0] acc;
    logic [7:0] operand;
    logic [7:0] flags_in;
    logic [7:0] result;
    logic [7:0] flags_out;
    modport core (output op, output acc, output operand, output flags_in,
                  input result, input flags_out);
    modport alu (input op, input acc, input operand, input flags_in,
                 output result, output flags_out);
endinterface // alu_link_if
`default_nettype wire

// *** rtl/byte_alu.sv ***
// byte arithmetic unit: eight-bit result and flags for every byte operation
`timescale 1ns/1ns
`default_nettype none
module byte_alu
    import alu_pkg::*;
(
    // link to the sequencing core
    alu_link_if.alu link
);
    logic [8:0] wide;
    logic [8:0] wide1;
    logic [4:0] low;
    logic [7:0] res;
    logic cin;
    logic cy;
    logic hc;
    logic adj_lo;
    logic adj_hi;

    // =========================================================
    // result and carries
    always_comb begin
        wide = 9'h000;
        wide1 = 9'h000;
        low = 5'h00;
        res = link.acc;
        cin = 1'b0;
        cy = link.flags_in[FLAG_CARRY];
        hc = link.flags_in[FLAG_HALF];
        adj_lo = 1'b0;
        adj_hi = 1'b0;
        case (link.op)
            op_add_with_carry: begin
                cin = link.flags_in[FLAG_CARRY];
                wide = {1'b0, link.acc} + {1'b0, link.operand} + {8'h00, cin};
                low = {1'b0, link.acc[3:0]} + {1'b0, link.operand[3:0]} + {4'h0, cin};
                res = wide[7:0];
                cy = wide[8];
                hc = low[4];
            end
            op_minus, op_minus_with_borrow, op_compare_operand: begin
                // add the complement: carry out clear means a borrow
                cin = (link.op == op_minus_with_borrow) ? ~link.flags_in[FLAG_CARRY] : 1'b1;
                wide = {1'b0, link.acc} + {1'b0, ~link.operand} + {8'h00, cin};
                low = {1'b0, link.acc[3:0]} + {1'b0, ~link.operand[3:0]} + {4'h0, cin};
                res = wide[7:0];
                cy = ~wide[8];
                hc = low[4];
            end
            op_increment_byte: begin
                wide = {1'b0, link.operand} + 9'h001;
                low = {1'b0, link.operand[3:0]} + 5'h01;
                res = wide[7:0];
                hc = low[4];
            end
            op_decrement_byte: begin
                wide = {1'b0, link.operand} + 9'h0FF;
                low = {1'b0, link.operand[3:0]} + 5'h0F;
                res = wide[7:0];
                hc = low[4];
            end
            op_and_operand: begin
                res = link.acc & link.operand;
                cy = 1'b0;
                hc = link.acc[3] | link.operand[3];
            end
            op_xor_operand: begin
                res = link.acc ^ link.operand;
                cy = 1'b0;
                hc = 1'b0;
            end
            op_or_operand: begin
                res = link.acc | link.operand;
                cy = 1'b0;
                hc = 1'b0;
            end
            op_decimal_adjust: begin
                adj_lo = (link.acc[3:0] > 4'h9) || link.flags_in[FLAG_HALF];
                wide1 = {1'b0, link.acc} + (adj_lo ? 9'h006 : 9'h000);
                low = {1'b0, link.acc[3:0]} + (adj_lo ? 5'h06 : 5'h00);
                hc = low[4];
                adj_hi = (wide1[7:4] > 4'h9) || link.flags_in[FLAG_CARRY] || wide1[8];
                wide = {1'b0, wide1[7:0]} + (adj_hi ? 9'h060 : 9'h000);
                res = wide[7:0];
                cy = link.flags_in[FLAG_CARRY] | wide1[8] | wide[8];
            end
            default: begin
                res = link.acc;
            end
        endcase
    end

    // =========================================================
    // standard flag rules
    always_comb begin
        link.flags_out = link.flags_in;
        link.flags_out[FLAG_SIGN] = res[7];
        link.flags_out[FLAG_ZERO] = (res == 8'h00);
        link.flags_out[FLAG_PARITY] = ~^res;
        link.flags_out[FLAG_HALF] = hc;
        link.flags_out[FLAG_CARRY] = cy;
    end

    assign link.result = res;

endmodule // byte_alu
`default_nettype wire

// *** test/mem_model.sv ***
// memory model on the operand path of the datapath
`timescale 1ns/1ns
`default_nettype none
module mem_model (
    // memory side
    input wire logic clk,
    input wire logic [15:0] addr,
    input wire logic rd,
    input wire logic wr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:255];
    initial rdata = 8'h00;
    // outside the answer cycle the byte toggles, so data taken one cycle late never passes for valid; two cycles late it repeats the answer
    always @(posedge clk) begin
        rdata <= rd ? mem[addr[7:0]] : ~rdata;
        if (wr) begin
            mem[addr[7:0]] <= wdata;
        end
    end
endmodule // mem_model
`default_nettype wire

// *** test/eight_bit_arith_logic_unit_tb.sv ***
// self-checking bench for the arithmetic and logic datapath
`timescale 1ns/1ns
`default_nettype none
module eight_bit_arith_logic_unit_tb;
    import alu_pkg::*;
    typedef struct {op_t op; logic [2:0] s; logic im; logic [7:0] a, f, d, ea, ef; int n;} row_t;
    logic clk, rst_n, ov, oi, bsy, dn, mrd, mwr, rwr, rrd;
    op_t oc;
    logic [2:0] os;
    logic [1:0] op2;
    logic [3:0] ra;
    logic [7:0] idat, mwd, mrdat, rwd, rrdat;
    logic [15:0] madr;
    int err_count = 0;
    int n_tests = 0;
    row_t rows [11] = '{
        '{op_add_with_carry, SEL_B, 1'h1, 8'h3A, 8'h01, 8'h05, 8'h40, 8'h10, 7},
        '{op_minus, SEL_B, 1'h0, 8'h05, 8'h00, 8'h06, 8'hFF, 8'h85, 4},
        '{op_minus_with_borrow, SEL_B, 1'h1, 8'h10, 8'h01, 8'h01, 8'h0E, 8'h00, 7},
        '{op_and_operand, SEL_B, 1'h0, 8'hF0, 8'h01, 8'h3C, 8'h30, 8'h14, 4},
        '{op_xor_operand, SEL_B, 1'h0, 8'h55, 8'h11, 8'h55, 8'h00, 8'h44, 4},
        '{op_or_operand, SEL_B, 1'h1, 8'h80, 8'h11, 8'h01, 8'h81, 8'h84, 7},
        '{op_compare_operand, SEL_B, 1'h0, 8'h10, 8'h00, 8'h20, 8'h10, 8'h95, 4},
        '{op_compare_operand, SEL_B, 1'h0, 8'h42, 8'h00, 8'h42, 8'h42, 8'h54, 4},
        '{op_increment_byte, SEL_A, 1'h0, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h55, 5},
        '{op_decrement_byte, SEL_A, 1'h0, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h84, 5},
        '{op_decimal_adjust, SEL_A, 1'h0, 8'h9B, 8'h00, 8'h00, 8'h01, 8'h11, 10}};
    eight_bit_arith_logic_unit eight_bit_arith_logic_unit_i (.MCLK(clk), .RESET_N(rst_n),
        .OP_VALID(ov), .OP_CODE(oc), .OP_SEL(os), .OP_PAIR(op2), .OP_IMM(oi), .IMM_DATA(idat),
        .BUSY(bsy), .DONE(dn), .MEM_ADDR(madr), .MEM_RD(mrd), .MEM_WR(mwr), .MEM_WDATA(mwd),
        .MEM_RDATA(mrdat), .REG_ADDR(ra), .REG_WDATA(rwd), .REG_WR(rwr), .REG_RD(rrd),
        .REG_RDATA(rrdat));
    mem_model mem_model_i (.clk(clk), .addr(madr), .rd(mrd), .wr(mwr), .wdata(mwd),
        .rdata(mrdat));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
            err_count++;
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        ra <= a;
        rwd <= d;
        rwr <= 1'h1;
        @(posedge clk);
        rwr <= 1'h0;
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        ra <= a;
        rrd <= 1'h1;
        @(posedge clk);
        rrd <= 1'h0;
        #1;
        chk({8'h00, rrdat}, {8'h00, e});
    endtask
    task automatic run_op(input op_t o, input logic [2:0] s, input logic [1:0] p,
                          input logic im, input logic [7:0] d, input int n);
        int k;
        k = 0;
        @(posedge clk);
        oc <= o;
        {os, op2, oi, idat, ov} <= {s, p, im, d, 1'h1};
        @(posedge clk);
        ov <= 1'h0;
        // count cycles from the accepting edge to the done pulse
        while (dn !== 1'h1 && k < 20) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk(16'(k), 16'(n));
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        err_count++;
        wrap_up();
    end
    initial begin
        {rst_n, ov, oi, rwr, rrd, os, op2, ra, idat, rwd} = '0;
        oc = op_add_with_carry;
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        reg_rd(4'h7, 8'h00);
        reg_rd(4'h6, 8'h00);
        reg_rd(4'hB, 8'h00);
        $display("reset and unmapped read done");
        foreach (rows[i]) begin
            reg_wr(4'h7, rows[i].a);
            reg_wr(4'h6, rows[i].f);
            reg_wr(4'h0, rows[i].d);
            run_op(rows[i].op, rows[i].s, 2'h0, rows[i].im, rows[i].d, rows[i].n);
            reg_rd(4'h7, rows[i].ea);
            reg_rd(4'h6, rows[i].ef);
        end
        $display("table rows done");
        {mem_model_i.mem[16], mem_model_i.mem[17]} = 16'h01FF;
        reg_wr(4'h4, 8'h00);
        reg_wr(4'h5, 8'h10);
        reg_wr(4'h7, 8'h03);
        reg_wr(4'h6, 8'h01);
        run_op(op_minus_with_borrow, SEL_MEM, 2'h0, 1'h0, 8'h00, 7);
        reg_rd(4'h7, 8'h01);
        reg_rd(4'h6, 8'h10);
        mem_model_i.mem[16] = 8'hFF;
        reg_wr(4'h6, 8'h01);
        run_op(op_increment_byte, SEL_MEM, 2'h0, 1'h0, 8'h00, 10);
        chk({8'h00, mem_model_i.mem[16]}, 16'h0000);
        reg_rd(4'h6, 8'h55);
        $display("memory operand tests done");
        reg_wr(4'h8, 8'hFF);
        reg_wr(4'h9, 8'hFF);
        run_op(op_increment_pair, SEL_B, PAIR_SP, 1'h0, 8'h00, 5);
        reg_rd(4'h8, 8'h00);
        reg_rd(4'h9, 8'h00);
        {rows[0].a, rows[0].f} = 16'h8000;
        reg_wr(4'h0, 8'h00);
        reg_wr(4'h1, 8'h00);
        run_op(op_decrement_pair, SEL_B, PAIR_BC, 1'h0, 8'h00, 5);
        reg_rd(4'h0, 8'hFF);
        reg_rd(4'h6, 8'h55);
        reg_wr(4'h0, 8'h80);
        reg_wr(4'h1, 8'h00);
        reg_wr(4'h4, 8'h80);
        reg_wr(4'h5, 8'h01);
        reg_wr(4'h6, 8'h54);
        run_op(op_pair_add_to_hl, SEL_B, PAIR_BC, 1'h0, 8'h00, 10);
        reg_rd(4'h4, 8'h00);
        reg_rd(4'h5, 8'h01);
        reg_rd(4'h6, 8'h55);
        $display("pair tests done");
        // status reads busy and a register write is refused while the operation runs
        fork
            run_op(op_minus, SEL_B, 2'h0, 1'h0, 8'h00, 4);
            begin
                @(posedge clk);
                reg_rd(4'hA, 8'h01);
                reg_wr(4'h0, 8'hEE);
            end
        join
        reg_rd(4'h0, 8'h80);
        reg_rd(4'h7, 8'h81);
        reg_rd(4'h6, 8'h95);
        $display("busy window tests done");
        // reset in the middle of an operation
        @(posedge clk);
        ov <= 1'h1;
        @(posedge clk);
        ov <= 1'h0;
        @(posedge clk);
        rst_n <= 1'h0;
        @(posedge clk);
        chk({8'h00, 7'h00, bsy}, 16'h0000);
        rst_n <= 1'h1;
        reg_rd(4'h7, 8'h00);
        reg_rd(4'h0, 8'h00);
        $display("mid-run reset done");
        wrap_up();
    end
endmodule // eight_bit_arith_logic_unit_tb
`default_nettype wire
